// [hw/orasr_core.sv]
// Purpose: Security-region program/read command logic and two-step software reset
// Assumes: Host clocks the link only while chip select is low
// Notes:   Frame capture runs on the serial clock; decisions run on the core clock
`timescale 1ns/1ps

// Contract
// - Program needs write latch already set
// - Program frame: 42h, 24-bit address, data
// - Max 256 bytes, only clears erased bits
// - Decode region select and byte offset
// - Locked region ignores program, permanently
// - Read frame: 48h, address, eight dummies
// - Sample opcode and address on rising edge
// - Read data on falling edge, MSB first
// - Offset increments, wraps FFh to 00h
// - Read runs until chip select rises
// - Reset aborts and clears volatile state
// - Reset only on 66h then 99h
// - Other instruction after 66h disarms reset
// - Refuse everything during reset recovery
// - In-progress flag high during self-timed cycle
// - Clear write latch when cycle completes
module orasr_core
  import orasr_pkg::*;
#(
  parameter int PROG_CYCLES = orasr_pkg::PROG_CYCLES_DEF  // Program time in core cycles
)
(
  input  wire logic                     clk,      // Core clock
  input  wire logic                     rst,      // Synchronous reset, active high
  input  wire logic                     sclk,     // Serial clock from host
  input  wire logic                     csN,      // Chip select, active low
  input  wire logic                     sdi,      // Serial data in
  output logic                          sdo,      // Serial data out
  output logic                          sdoEn,    // Output enable of serial data out
  input  wire logic                     volLoad,  // Load volatile settings, pulse
  input  wire orasr_pkg::orasr_vol_type volIn,    // Volatile settings to load
  input  wire logic [2:0]               lockIn,   // Region lock levels from storage
  output orasr_pkg::orasr_stat_type     status    // Registered status
);
  import orasr_pkg::*;

  // Storage arrays
  logic [7:0]  otpMem  [0:MEM_WORDS-1];  // Region contents, written on core clock
  logic [7:0]  pageBuf [0:BUF_WORDS-1];  // Program data, written on serial clock

  // Serial side, cleared by chip select
  logic [5:0]  bitCnt;        // Rising edges seen, saturates at header length
  logic [2:0]  dataBit;       // Bit position within a data byte
  logic [7:0]  wrIdx;         // Buffer write index, wraps
  logic        busyS1;        // First stage of busy synchroniser
  logic        busyS2;        // Synchronised refuse level
  logic [7:0]  shiftIn;       // Incoming bits
  logic [5:0]  next_bitCnt;
  logic [2:0]  next_dataBit;
  logic [7:0]  next_wrIdx;
  logic [7:0]  next_shiftIn;

  // Serial side, held across the frame end for the core clock
  logic [7:0]  opcodeReg;     // Last opcode
  logic [23:0] addrReg;       // Last address
  logic        holdOpValid;   // A whole opcode arrived
  logic [8:0]  holdCount;     // Complete data bytes, saturating
  logic        holdPartial;   // Frame ended inside a byte
  logic [7:0]  next_opcodeReg;
  logic [23:0] next_addrReg;
  logic        next_holdOpValid;
  logic [8:0]  next_holdCount;
  logic        next_holdPartial;
  logic        bufWe;         // Write a data byte into the buffer
  logic [7:0]  bufData;       // Byte completed on this edge

  // Read output, falling edge
  logic [2:0]  outIdx;        // Bit position of the outgoing byte
  logic [8:0]  rdOff;         // Next offset to read
  logic        rdStarted;     // First byte already fetched
  logic [7:0]  outShift;      // Remaining bits of current byte
  logic [2:0]  next_outIdx;
  logic [8:0]  next_rdOff;
  logic        next_rdStarted;
  logic [7:0]  next_outShift;
  logic        next_sdo;
  logic        next_sdoEn;
  logic        addrOk;        // Address selects a region
  logic [1:0]  regIdx;        // Region number minus one
  logic        readGo;        // Read data phase active and allowed
  logic [8:0]  curOff;        // Offset for the byte fetched now
  logic [7:0]  rdByte;        // Byte fetched now

  // Core side
  logic            csS1;      // First stage of chip select synchroniser
  logic            csS2;      // Synchronised chip select
  logic            csPrev;    // Previous synchronised chip select
  orasr_state_type state;
  logic [CNT_W-1:0] timer;    // Remaining cycles of the current operation
  logic [8:0]      progIdx;   // Bytes copied so far
  logic [8:0]      progCount; // Bytes to copy
  logic [10:0]     progBase;  // Region and start offset
  logic [2:0]      lockState; // Latched locks
  orasr_stat_type  next_status;
  orasr_state_type next_state;
  logic [CNT_W-1:0] next_timer;
  logic [8:0]      next_progIdx;
  logic [8:0]      next_progCount;
  logic [10:0]     next_progBase;
  logic [2:0]      next_lockState;
  logic            frameEnd;  // Chip select has just risen
  logic            memWe;     // Program one byte
  logic [10:0]     memAddr;   // Byte being programmed
  logic [7:0]      memData;   // Value after programming
  logic [7:0]      progOffLo; // Low offset with page wrap

  // Region decode of the captured address
  always_comb
  begin
    addrOk = (addrReg[23:16] == ADR_HI_ZERO) && (addrReg[15:12] >= REG_SEL_MIN)
          && (addrReg[15:12] <= REG_SEL_MAX) && (addrReg[11:9] == ADR_GAP_ZERO);
    regIdx = addrReg[13:12] - 2'h1;
  end

  // Next values of the serial rising-edge logic
  always_comb
  begin
    next_bitCnt      = (bitCnt == HDR_BITS) ? bitCnt : bitCnt + 6'h01;
    next_shiftIn     = {shiftIn[6:0], sdi};
    next_dataBit     = dataBit;
    next_wrIdx       = wrIdx;
    next_opcodeReg   = opcodeReg;
    next_addrReg     = addrReg;
    next_holdOpValid = holdOpValid;
    next_holdCount   = holdCount;
    next_holdPartial = holdPartial;
    bufWe            = 1'b0;
    bufData          = next_shiftIn;
    if (bitCnt == 6'h00)
    begin
      // New frame: forget what the last one left behind
      next_holdOpValid = 1'b0;
      next_holdCount   = 9'h000;
      next_holdPartial = 1'b0;
    end
    if (bitCnt == OPC_LAST_BIT)
    begin
      next_opcodeReg   = next_shiftIn;
      next_holdOpValid = 1'b1;
    end
    else if (bitCnt > OPC_LAST_BIT && bitCnt <= ADR_LAST_BIT)
    begin
      next_addrReg = {addrReg[22:0], sdi};
    end
    else if (bitCnt > ADR_LAST_BIT && opcodeReg == OP_PROGRAM)
    begin
      // Data bytes; the buffer is frozen while a cycle runs
      next_dataBit     = dataBit + 3'h1;
      next_holdPartial = (next_dataBit != 3'h0);
      if (dataBit == 3'h7)
      begin
        bufWe          = !busyS2;
        next_wrIdx     = wrIdx + 8'h01;
        next_holdCount = (holdCount == BUF_LIMIT) ? holdCount : holdCount + 9'h001;
      end
    end
  end

  // Frame counters, cleared whenever chip select is high
  always_ff @(posedge sclk or posedge csN)
  begin
    if (csN)
    begin
      bitCnt  <= 6'h00;
      dataBit <= 3'h0;
      wrIdx   <= 8'h00;
      shiftIn <= 8'h00;
      busyS1  <= 1'b0;
      busyS2  <= 1'b0;
    end
    else
    begin
      bitCnt  <= next_bitCnt;
      dataBit <= next_dataBit;
      wrIdx   <= next_wrIdx;
      shiftIn <= next_shiftIn;
      busyS1  <= status.refusing;
      busyS2  <= busyS1;
    end
  end

  // Captured frame contents; must survive the chip select rise
  always_ff @(posedge sclk)
  begin
    opcodeReg   <= next_opcodeReg;
    addrReg     <= next_addrReg;
    holdOpValid <= next_holdOpValid;
    holdCount   <= next_holdCount;
    holdPartial <= next_holdPartial;
    if (bufWe)
    begin
      pageBuf[wrIdx] <= bufData;
    end
  end

  // Next values of the falling-edge read output
  always_comb
  begin
    readGo = holdOpValid && (opcodeReg == OP_READ) && (bitCnt == HDR_BITS)
          && addrOk && !busyS2;
    curOff         = rdStarted ? rdOff : addrReg[8:0];
    rdByte         = otpMem[{regIdx, curOff}];
    next_outIdx    = outIdx;
    next_rdOff     = rdOff;
    next_rdStarted = rdStarted;
    next_outShift  = outShift;
    next_sdo       = sdo;
    next_sdoEn     = sdoEn;
    if (readGo)
    begin
      next_sdoEn  = 1'b1;
      next_outIdx = outIdx + 3'h1;
      if (outIdx == 3'h0)
      begin
        // Fetch a byte and present its top bit
        next_sdo       = rdByte[7];
        next_outShift  = {rdByte[6:0], 1'b0};
        next_rdOff     = {curOff[8], curOff[7:0] + 8'h01};
        next_rdStarted = 1'b1;
      end
      else
      begin
        next_sdo      = outShift[7];
        next_outShift = {outShift[6:0], 1'b0};
      end
    end
  end

  // Read output ends with the frame itself
  always_ff @(negedge sclk or posedge csN)
  begin
    if (csN)
    begin
      outIdx    <= 3'h0;
      rdOff     <= 9'h000;
      rdStarted <= 1'b0;
      outShift  <= 8'h00;
      sdo       <= 1'b0;
      sdoEn     <= 1'b0;
    end
    else
    begin
      outIdx    <= next_outIdx;
      rdOff     <= next_rdOff;
      rdStarted <= next_rdStarted;
      outShift  <= next_outShift;
      sdo       <= next_sdo;
      sdoEn     <= next_sdoEn;
    end
  end

  // Core-side decisions: frame instructions once per finished frame, program copy and timers every cycle
  always_comb
  begin
    frameEnd       = csS2 && !csPrev;
    next_status    = status;
    next_state     = state;
    next_timer     = timer;
    next_progIdx   = progIdx;
    next_progCount = progCount;
    next_progBase  = progBase;
    next_lockState = lockState | lockIn;
    progOffLo      = progBase[7:0] + progIdx[7:0];
    memAddr        = {progBase[10:8], progOffLo};
    memData        = otpMem[memAddr] & pageBuf[progIdx[7:0]];
    memWe          = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (volLoad)
        begin
          next_status.vol = volIn;
        end
      end
      ST_PROG:
      begin
        // Copy one byte a cycle while the timer runs
        if (progIdx != progCount)
        begin
          memWe        = 1'b1;
          next_progIdx = progIdx + 9'h001;
        end
        if (timer != {CNT_W{1'b0}})
        begin
          next_timer = timer - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        else if (progIdx == progCount)
        begin
          next_state                       = ST_IDLE;
          next_status.op_in_progress_flag  = 1'b0;
          next_status.write_latch_flag     = 1'b0;
          next_status.refusing             = 1'b0;
        end
      end
      ST_RECOVER:
      begin
        // Nothing is taken until the recovery time has passed
        if (timer != {CNT_W{1'b0}})
        begin
          next_timer = timer - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        else
        begin
          next_state           = ST_IDLE;
          next_status.refusing = 1'b0;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    // Reset instructions reach the core even while a cycle runs
    if (frameEnd && holdOpValid && state != ST_RECOVER)
    begin
      if (opcodeReg == OP_RST_EN)
      begin
        next_status.reset_armed = 1'b1;
      end
      else if (opcodeReg == OP_RST_GO && status.reset_armed)
      begin
        // Abort and return to power-on values; locks are kept
        next_state                      = ST_RECOVER;
        next_timer                      = CNT_W'(RST_CYCLES);
        next_status.write_latch_flag    = 1'b0;
        next_status.op_in_progress_flag = 1'b0;
        next_status.reset_armed         = 1'b0;
        next_status.refusing            = 1'b1;
        next_status.vol                 = '0;
        memWe                           = 1'b0;
      end
      else
      begin
        next_status.reset_armed = 1'b0;
        if (state == ST_IDLE)
        begin
          if (opcodeReg == OP_WR_EN)
          begin
            next_status.write_latch_flag = 1'b1;
          end
          else if (opcodeReg == OP_WR_DIS)
          begin
            next_status.write_latch_flag = 1'b0;
          end
          else if (opcodeReg == OP_PROGRAM && status.write_latch_flag && addrOk
                && !lockState[regIdx] && holdCount != 9'h000 && !holdPartial)
          begin
            next_state                      = ST_PROG;
            next_timer                      = CNT_W'(PROG_CYCLES);
            next_progIdx                    = 9'h000;
            next_progCount                  = holdCount;
            next_progBase                   = {regIdx, addrReg[8:0]};
            next_status.op_in_progress_flag = 1'b1;
            next_status.refusing            = 1'b1;
          end
        end
      end
    end
    next_status.otp_lock_bits = lockState;
  end

  // Core-side registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      csS1      <= 1'b1;
      csS2      <= 1'b1;
      csPrev    <= 1'b1;
      state     <= ST_IDLE;
      timer     <= {CNT_W{1'b0}};
      progIdx   <= 9'h000;
      progCount <= 9'h000;
      progBase  <= 11'h000;
      lockState <= 3'h0;
      status    <= '0;
    end
    else
    begin
      csS1      <= csN;
      csS2      <= csS1;
      csPrev    <= csS2;
      state     <= next_state;
      timer     <= next_timer;
      progIdx   <= next_progIdx;
      progCount <= next_progCount;
      progBase  <= next_progBase;
      lockState <= next_lockState;
      status    <= next_status;
    end
  end

  // Region array; power-on reset models a factory-erased part
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        otpMem[i] <= ERASED_BYTE;
      end
    end
    else if (memWe)
    begin
      otpMem[memAddr] <= memData;
    end
  end

endmodule

// [hw/orasr_pkg.sv]
// Purpose: Shared constants and types for the security-region access and soft reset logic
// Assumes: Serial link is mode 0 style, sampled on rising and driven on falling edges
// Notes:   All timing counts derive from the 10 MHz core clock
package orasr_pkg;

  // Instruction codes
  localparam logic [7:0] OP_PROGRAM   = 8'h42;  // Security-region program
  localparam logic [7:0] OP_READ      = 8'h48;  // Security-region read
  localparam logic [7:0] OP_RST_EN    = 8'h66;  // Arm software reset
  localparam logic [7:0] OP_RST_GO    = 8'h99;  // Perform software reset
  localparam logic [7:0] OP_WR_EN     = 8'h06;  // Set write latch
  localparam logic [7:0] OP_WR_DIS    = 8'h04;  // Clear write latch

  // Frame layout in serial clock edges
  localparam logic [5:0] OPC_LAST_BIT = 6'h07;  // Edge index of last opcode bit
  localparam logic [5:0] ADR_LAST_BIT = 6'h1F;  // Edge index of last address bit
  localparam logic [5:0] HDR_BITS     = 6'h28;  // Opcode, address and eight dummy edges

  // Address field layout
  localparam logic [7:0] ADR_HI_ZERO  = 8'h00;  // Required upper address byte
  localparam logic [3:0] REG_SEL_MIN  = 4'h1;   // First region select code
  localparam logic [3:0] REG_SEL_MAX  = 4'h3;   // Last region select code
  localparam logic [2:0] ADR_GAP_ZERO = 3'h0;   // Required bits above the offset

  // Sizes
  localparam int         MEM_WORDS    = 1536;   // Three regions of 512 bytes
  localparam int         BUF_WORDS    = 256;    // Largest single program
  localparam logic [8:0] BUF_LIMIT    = 9'h100; // Byte count saturation point
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;  // Value of an erased location

  // Timing
  localparam int         CLK_PERIOD_NS = 100;   // Core clock period
  localparam int         PROG_TIME_US  = 1000;  // Self-timed program duration
  localparam int         RST_TIME_US   = 30;    // Reset recovery duration
  localparam int PROG_CYCLES_DEF = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CYCLES      = (RST_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         CNT_W         = 16;    // Width of the operation timer

  // Volatile settings loaded by the surrounding device logic
  typedef struct packed {
    logic       suspend_flag;         // Suspend state
    logic [7:0] continuous_read_bits; // Continuous read mode setting
    logic [2:0] wrap_length_bits;     // Wrap setting
  } orasr_vol_type;

  // Status seen by the surrounding device logic
  typedef struct packed {
    logic          write_latch_flag;     // Write latch
    logic          op_in_progress_flag;  // Self-timed cycle running
    logic          refusing;             // Instructions refused now; reset instructions still taken while programming
    logic          reset_armed;          // Reset enable seen
    logic [2:0]    otp_lock_bits;        // Latched region locks
    orasr_vol_type vol;                  // Volatile settings
  } orasr_stat_type;

  // Core control states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROG,
    ST_RECOVER
  } orasr_state_type;

endpackage

// [test/orasr_core_properties.sv]
// Purpose: Concurrent checks on the security-region and soft reset block
// Assumes: Link clock runs only inside frames
// Notes:   Helper counters give the checks their cycle figures
`timescale 1ns/1ps
module orasr_core_properties
  import orasr_pkg::*;
#(
  parameter int PROG_CYCLES = 400  // Program time in core cycles
)
(
  input wire logic                      clk,      // Core clock
  input wire logic                      rst,      // Synchronous reset
  input wire logic                      sclk,     // Link clock
  input wire logic                      csN,      // Chip select, active low
  input wire logic                      sdi,      // Link data in
  input wire logic                      sdo,      // Link data out
  input wire logic                      sdoEn,    // Data out enable
  input wire logic                      volLoad,  // Settings load pulse
  input wire orasr_pkg::orasr_vol_type  volIn,    // Settings to load
  input wire logic [2:0]                lockIn,   // Lock levels
  input wire orasr_pkg::orasr_stat_type status    // Status
);
  logic [15:0] busyCnt, next_busyCnt;  // Cycles spent programming
  logic [15:0] recCnt, next_recCnt;    // Cycles spent recovering
  logic [5:0]  edgeCnt, next_edgeCnt;  // Rising link edges this frame
  logic [7:0]  rxOp, next_rxOp;        // First byte of the frame

  // Core counters restart whenever their condition drops
  always_comb
  begin
    next_busyCnt = status.op_in_progress_flag ? busyCnt + 16'h0001 : 16'h0000;
    next_recCnt = (status.refusing && !status.op_in_progress_flag) ? recCnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk)
  begin
    busyCnt <= rst ? 16'h0000 : next_busyCnt;
    recCnt <= rst ? 16'h0000 : next_recCnt;
  end

  // Link counters; saturate so a long read cannot wrap back to the header
  always_comb
  begin
    next_edgeCnt = (edgeCnt == 6'h3F) ? edgeCnt : edgeCnt + 6'h01;
    next_rxOp = (edgeCnt < 6'h08) ? {rxOp[6:0], sdi} : rxOp;
  end
  always_ff @(posedge sclk or posedge csN)
    if (csN)
      {edgeCnt, rxOp} <= 14'h0000;
    else
      {edgeCnt, rxOp} <= {next_edgeCnt, next_rxOp};

  a_busy_refuses: assert property (@(posedge clk) disable iff (rst)
    status.op_in_progress_flag |-> status.refusing) else $error("busy without refusal");
  a_prog_bounded: assert property (@(posedge clk) disable iff (rst)
    status.op_in_progress_flag |-> busyCnt <= PROG_CYCLES + 1) else $error("program too long");
  a_prog_full: assert property (@(posedge clk) disable iff (rst)
    $fell(status.op_in_progress_flag) && !status.refusing |-> $past(busyCnt) >= PROG_CYCLES - 1)
    else $error("program too short");
  a_wel_done: assert property (@(posedge clk) disable iff (rst)
    $fell(status.op_in_progress_flag) |-> !status.write_latch_flag) else $error("latch kept");
  a_start_wel: assert property (@(posedge clk) disable iff (rst)
    $rose(status.op_in_progress_flag) |-> $past(status.write_latch_flag))
    else $error("program without latch");
  a_start_cs_high: assert property (@(posedge clk) disable iff (rst)
    $rose(status.op_in_progress_flag) |-> $past(csN)) else $error("program inside frame");
  a_reset_clears: assert property (@(posedge clk) disable iff (rst)
    ($rose(status.refusing) && !status.op_in_progress_flag)
    || ($fell(status.op_in_progress_flag) && status.refusing)
    |-> !status.write_latch_flag && !status.reset_armed && status.vol == 12'h000)
    else $error("reset left state");
  a_reset_armed: assert property (@(posedge clk) disable iff (rst)
    ($rose(status.refusing) && !status.op_in_progress_flag)
    || ($fell(status.op_in_progress_flag) && status.refusing)
    |-> $past(status.reset_armed)) else $error("reset without arming");
  a_recover_len: assert property (@(posedge clk) disable iff (rst)
    $fell(status.refusing) && !$past(status.op_in_progress_flag)
    |-> $past(recCnt) >= RST_CYCLES - 1 && $past(recCnt) <= RST_CYCLES + 1)
    else $error("recovery length wrong");
  a_locks_kept: assert property (@(posedge clk) disable iff (rst)
    ($past(status.otp_lock_bits) & ~status.otp_lock_bits) == 3'h0) else $error("lock lost");
  a_cs_quiet: assert property (@(posedge clk) disable iff (rst)
    csN |-> !sdoEn) else $error("driving while deselected");
  a_read_order: assert property (@(posedge sclk) disable iff (csN)
    sdoEn |-> edgeCnt >= HDR_BITS && rxOp == OP_READ) else $error("data before dummies");
endmodule

bind orasr_core orasr_core_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
  .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
  .volLoad(volLoad), .volIn(volIn), .lockIn(lockIn), .status(status));

// [test/orasr_core_tb_top.sv]
// Purpose: Self-checking bench for the security-region and soft reset block
// Assumes: Core clock 100 ns, link clock 15 ns inside frames
// Notes:   Program time shortened to 400 core cycles
`timescale 1ns/1ps
module orasr_core_tb_top;
  import orasr_pkg::*;
  localparam int  PROG_SIM = 400;  // Shortened program time
  logic           clk;             // Core clock
  logic           rst;             // Synchronous reset
  logic           sclk;            // Link clock from the host model
  logic           csN;             // Chip select from the host model
  logic           sdi;             // Data towards the design
  logic           sdo;             // Data from the design
  logic           sdoEn;           // Design drives sdo
  logic           volLoad;         // Settings load pulse
  orasr_vol_type  volIn;           // Settings to load
  logic [2:0]     lockIn;          // Lock levels
  orasr_stat_type status;          // Status from the design
  int             mismatches;      // Failed comparisons
  int             checksDone;      // Comparisons made

  always #50 clk = ~clk;  // 10 MHz core clock

  orasr_core #(.PROG_CYCLES(PROG_SIM)) DUT (
    .clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn),
    .volLoad(volLoad), .volIn(volIn), .lockIn(lockIn), .status(status));
  orasr_host host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoEn(sdoEn));

  task automatic summarize();
    if (mismatches == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Unknowns never match
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Chip-select rise needs three core cycles to be acted on
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask

  // Opcode and address, then whatever sits in txBuf[4] onwards
  task automatic send(input logic [7:0] op, input logic [23:0] adr, input int nBits);
    host.txBuf[0] = op;
    {host.txBuf[1], host.txBuf[2], host.txBuf[3]} = adr;
    host.frame(nBits);
    settle();
  endtask

  task automatic prog(input logic [23:0] adr, input logic [7:0] d0, input int nBits);
    send(OP_WR_EN, 24'h000000, 8);
    host.txBuf[4] = d0;
    send(OP_PROGRAM, adr, nBits);
  endtask

  task automatic waitIdle();
    for (int i = 0; i < 1000 && status.op_in_progress_flag !== 1'b0; i++)
      @(negedge clk);
    chk(status.op_in_progress_flag, 1'b0);
  endtask

  // Three bytes read after the dummy clocks
  task automatic readBack(input logic [23:0] adr, input logic [23:0] exp);
    send(OP_READ, adr, 64);
    chk({host.rxBuf[5], host.rxBuf[6], host.rxBuf[7]}, exp);
  endtask

  task automatic t_power_on();
    chk(24'(status), 24'h000000);
    readBack(24'h001000, 24'hFFFFFF);
  endtask

  // Refused without latch; then a program across the FFh offset
  task automatic t_program();
    host.txBuf[4] = 8'h00;
    send(OP_PROGRAM, 24'h001010, 40);
    chk(status.op_in_progress_flag, 1'b0);
    host.txBuf[5] = 8'h3C;
    host.txBuf[6] = 8'h0F;
    prog(24'h0010FE, 8'hA5, 56);
    chk(status.op_in_progress_flag, 1'b1);
    waitIdle();
    chk(status.write_latch_flag, 1'b0);
    readBack(24'h0010FE, 24'hA53C0F);
    prog(24'h0010FE, 8'hF0, 40);
    waitIdle();
    readBack(24'h0010FE, 24'hA03C0F);
    prog(24'h003100, 8'h5A, 40);
    waitIdle();
    readBack(24'h003100, 24'h5AFFFF);
    readBack(24'h001010, 24'hFFFFFF);
  endtask

  // Bad addresses and broken frames start nothing
  task automatic t_rejects();
    logic [23:0] bad [4];
    bad = '{24'h000010, 24'h004010, 24'h001210, 24'h011010};
    foreach (bad[i])
    begin
      prog(bad[i], 8'h00, 40);
      chk(status.op_in_progress_flag, 1'b0);
    end
    send(OP_PROGRAM, 24'h001020, 44);
    chk(status.op_in_progress_flag, 1'b0);
    send(OP_PROGRAM, 24'h001020, 32);
    chk(status.op_in_progress_flag, 1'b0);
    send(OP_WR_DIS, 24'h000000, 8);
    chk(status.write_latch_flag, 1'b0);
  endtask

  // A latched lock outlives its input and bars its region
  task automatic t_lock();
    lockIn = 3'b010;
    settle();
    lockIn = 3'b000;
    settle();
    chk(status.otp_lock_bits, 3'b010);
    prog(24'h002000, 8'h00, 40);
    chk(status.op_in_progress_flag, 1'b0);
  endtask

  // Arm, disarm, abort a program, refuse during recovery
  task automatic t_reset();
    volIn = '{1'b1, 8'hA5, 3'h5};
    volLoad = 1'b1;
    @(negedge clk);
    volLoad = 1'b0;
    settle();
    chk(status.vol, 12'hD2D);
    send(OP_RST_EN, 24'h000000, 8);
    chk(status.reset_armed, 1'b1);
    send(OP_WR_EN, 24'h000000, 8);
    chk(status.reset_armed, 1'b0);
    send(OP_RST_GO, 24'h000000, 8);
    chk(status.refusing, 1'b0);
    prog(24'h001030, 8'h00, 40);
    send(OP_RST_EN, 24'h000000, 8);
    send(OP_RST_GO, 24'h000000, 8);
    chk(24'(status), {5'h00, 4'b0010, 3'b010, 12'h000});
    send(OP_READ, 24'h001000, 64);
    chk(host.sawEn, 1'b0);
    send(OP_RST_EN, 24'h000000, 8);
    chk(status.reset_armed, 1'b0);
    for (int i = 0; i < 400 && status.refusing !== 1'b0; i++)
      @(negedge clk);
    send(OP_RST_EN, 24'h000000, 8);
    chk(status.reset_armed, 1'b1);
    readBack(24'h001000, 24'h0FFFFF);
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    volLoad = 1'b0;
    volIn = '0;
    lockIn = 3'b000;
    mismatches = 0;
    checksDone = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_power_on();
    t_program();
    t_rejects();
    t_lock();
    t_reset();
    summarize();
  end

  // Watchdog: the run needs well under one millisecond
  initial
  begin
    #2000000;
    mismatches++;
    summarize();
  end
endmodule

// [test/orasr_host.sv]
// Purpose: Host controller model driving the serial link
// Assumes: Mode 0 timing, 15 ns link clock, still between frames
// Notes:   Bytes to send and bytes seen sit in small arrays
`timescale 1ns/1ps
module orasr_host
(
  output logic      sclk,   // Link clock
  output logic      csN,    // Chip select, active low
  output logic      sdi,    // Data towards the device
  input  wire logic sdo,    // Data from the device
  input  wire logic sdoEn   // Device drives sdo
);
  logic [7:0] txBuf [0:15];  // Bytes to send, first one first
  logic [7:0] rxBuf [0:15];  // Bytes seen on sdo at rising edges
  logic       sawEn;         // Device drove sdo in this frame

  initial
  begin
    sclk = 1'b0;
    csN = 1'b0;
    sdi = 1'b0;
    #1 csN = 1'b1;  // A real rising edge clears the frame logic
  end

  // One frame of nBits clocks; a count off a byte boundary makes a broken frame
  task automatic frame(input int nBits);
    csN = 1'b0;
    sawEn = 1'b0;
    for (int i = 0; i < nBits; i++)
    begin
      sdi = txBuf[i / 8][7 - (i % 8)];
      #7.5 sclk = 1'b1;
      rxBuf[i / 8][7 - (i % 8)] = sdoEn ? sdo : 1'bx;  // Undriven line reads unknown
      sawEn = sawEn | sdoEn;
      #7.5 sclk = 1'b0;
    end
    #7 csN = 1'b1;
    sdi = ~sdi;  // Released line must not look held
  endtask
endmodule
